// ---- rtl/radc_ctrl.sv ----
// radc_ctrl: alarm month and year settings and calendar clock control
//
// What this block does
// - alarm month tens: one bit, reset zero
// - alarm month units: BCD, resets to one
// - alarm year tens: BCD, reset zero
// - alarm year units: BCD, reset zero
// - view zero reads live time registers
// - view one reads snapshot shadow copies
// - load bit loads counter with compensation
// - test mode with auto compensation set compensates at terminal count
// - format bit picks 24 or 12 hours
// - format change never disturbs the count
// - hour reads follow current format
// - auto compensation bit enables drift correction
// - rounding bit rounds time to minute
// - running flag follows run with delay
// - alarm enable raises one interrupt on match
`timescale 1ns/10ps
`default_nettype none
module radc_ctrl
	import radc_pkg::*;
#(
	// bus address of the device; value arbitrary
	parameter logic [6:0] DEV_ADDR = 7'h2D,
	parameter int         DIV      = TICK_DIV
)(
	input  wire logic              CLK_IN,
	input  wire logic              RST_IN,
	input  wire logic              SCL_IN,
	input  wire logic              SDA_IN,
	output logic                   SDA_OUT,
	output logic                   SDA_OE_OUT,
	input  wire logic [7:0]        LIVE_SEC_IN,
	input  wire logic [7:0]        LIVE_MIN_IN,
	input  wire logic [7:0]        LIVE_HOUR_IN,
	input  wire logic [7:0]        LIVE_DAY_IN,
	input  wire logic [7:0]        LIVE_MON_IN,
	input  wire logic [7:0]        LIVE_YEAR_IN,
	input  wire logic [7:0]        LIVE_WDAY_IN,
	input  wire logic [COMP_W-1:0] COMP_VALUE_IN,
	input  wire logic              ALARM_LOW_MATCH_IN,
	input  wire logic              ROUND_DONE_IN,
	output logic                   RUN_OUT,
	output logic                   SEC_TICK_OUT,
	output logic                   COMP_APPLY_OUT,
	output logic                   HOUR_12_OUT,
	output logic                   ROUND_REQ_OUT,
	output logic                   ALARM_IRQ_OUT
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic                     mon_tens;
		logic [3:0]               mon_units;
		logic [7:0]               year;
		logic [7:0]               ctrl;
		logic                     irq_en;
		logic                     load_p;
		logic                     round_req;
		logic                     match_d;
		logic                     alarm_irq;
		logic                     sda_lo;
		logic [NUM_TIME-1:0][7:0] shadow;
	} radc_state_s;

	localparam radc_state_s ST_RST = '{
		mon_tens:  ALM_MON_TENS_RST,
		mon_units: ALM_MON_UNITS_RST,
		year:      ALM_YEAR_RST,
		ctrl:      CTRL_RST,
		irq_en:    1'b0,
		load_p:    1'b0,
		round_req: 1'b0,
		match_d:   1'b0,
		alarm_irq: 1'b0,
		sda_lo:    1'b0,
		shadow:    '0
	};

	radc_state_s              q_r;
	radc_state_s              q_nxt;
	logic [NUM_TIME-1:0][7:0] live;
	logic                     wr_stb;
	logic [7:0]               addr;
	logic [7:0]               wdata;
	logic [7:0]               rdata;
	logic [7:0]               tv;
	logic [7:0]               hour_shown;
	logic [TIME_IDX_W-1:0]    tidx;
	logic                     running;
	logic                     hour_top;
	logic                     match;
	logic                     rnd;

	// live time in register order
	assign live[0] = LIVE_SEC_IN;
	assign live[1] = LIVE_MIN_IN;
	assign live[2] = LIVE_HOUR_IN;
	assign live[3] = LIVE_DAY_IN;
	assign live[4] = LIVE_MON_IN;
	assign live[5] = LIVE_YEAR_IN;
	assign live[6] = LIVE_WDAY_IN;
	assign tidx = addr[TIME_IDX_W-1:0];
	assign hour_top = (LIVE_MIN_IN == 8'h00) && (LIVE_SEC_IN == 8'h00);

	// ------------------------------------------------------------
	// 24-hour BCD to 12-hour BCD with pm flag in bit 7
	// ------------------------------------------------------------
	function automatic logic [7:0] hour_to_12(input logic [7:0] h24);
		logic [4:0] bin;
		logic [4:0] b12;
		logic       pm;
		logic       tens;
		logic [3:0] units;
		bin = 5'(h24[5:4]) * BCD_TEN + 5'(h24[3:0]);
		pm = (bin >= NOON);
		if (bin == 5'h00) begin
			b12 = NOON;
		end else if (bin > NOON) begin
			b12 = bin - NOON;
		end else begin
			b12 = bin;
		end
		tens = (b12 >= BCD_TEN);
		units = tens ? 4'(b12 - BCD_TEN) : b12[3:0];
		return {pm, 2'h0, tens, units};
	endfunction

	// ------------------------------------------------------------
	// register writes, snapshot, alarm match
	// ------------------------------------------------------------
	always_comb begin
		q_nxt = q_r;
		q_nxt.load_p = 1'b0;
		q_nxt.round_req = 1'b0;
		if (ROUND_DONE_IN) begin
			q_nxt.ctrl[CB_ROUND] = 1'b0;
		end
		rnd = q_nxt.ctrl[CB_ROUND];
		if (wr_stb) begin
			unique case (addr)
				ADDR_ALM_MON: begin
					q_nxt.mon_tens = wdata[MB_TENS];
					q_nxt.mon_units = wdata[UNITS_W-1:0];
				end
				ADDR_ALM_YEAR: begin
					q_nxt.year = wdata;
				end
				ADDR_CTRL: begin
					// only a 0 to 1 change of the snapshot bit captures
					if (wdata[CB_SNAP] && !q_r.ctrl[CB_SNAP]) begin
						q_nxt.shadow = live;
					end
					q_nxt.load_p = wdata[CB_LOAD];
					q_nxt.round_req = wdata[CB_ROUND];
					// fmt, test, auto, view and run simply stored
					q_nxt.ctrl = wdata;
					// a set in the same cycle as done wins
					q_nxt.ctrl[CB_ROUND] = rnd || wdata[CB_ROUND];
				end
				ADDR_IRQC: begin
					q_nxt.irq_en = wdata[IB_ALARM];
				end
				default: begin
				end
			endcase
		end
		q_nxt.match_d = match;
		q_nxt.alarm_irq = match && !q_r.match_d && q_r.irq_en;
	end

	// ------------------------------------------------------------
	// alarm compare
	// ------------------------------------------------------------
	always_comb begin
		// level compare; the edge is taken in the state
		match = ALARM_LOW_MATCH_IN;
		if (LIVE_MON_IN != {3'h0, q_r.mon_tens, q_r.mon_units}) begin
			match = 1'b0;
		end
		if (LIVE_YEAR_IN != q_r.year) begin
			match = 1'b0;
		end
	end

	// ------------------------------------------------------------
	// time register view and hour presentation
	// ------------------------------------------------------------
	always_comb begin
		// index 7 has no time register behind it
		tv = 8'h00;
		if (tidx < TIME_IDX_W'(NUM_TIME)) begin
			if (q_r.ctrl[CB_VIEW]) begin
				tv = q_r.shadow[tidx];
			end else begin
				tv = live[tidx];
			end
		end
		hour_shown = tv;
		if (addr == ADDR_HOUR && q_r.ctrl[CB_FMT]) begin
			hour_shown = hour_to_12(tv);
		end
	end

	// ------------------------------------------------------------
	// read data
	// ------------------------------------------------------------
	always_comb begin
		rdata = 8'h00;
		if (addr < 8'(NUM_TIME)) begin
			rdata = hour_shown;
		end else begin
			unique case (addr)
				ADDR_ALM_MON: begin
					rdata = {3'h0, q_r.mon_tens, q_r.mon_units};
				end
				ADDR_ALM_YEAR: begin
					rdata = q_r.year;
				end
				ADDR_CTRL: begin
					rdata = q_r.ctrl;
				end
				ADDR_STAT: begin
					rdata[SB_RUN] = running;
				end
				ADDR_IRQC: begin
					rdata[IB_ALARM] = q_r.irq_en;
				end
				default: begin
					rdata = 8'h00;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			q_r <= ST_RST;
		end else begin
			q_r <= q_nxt;
		end
	end

	// ------------------------------------------------------------
	// control interface and sub-second counter
	// ------------------------------------------------------------
	radc_i2c #(
		.DEV_ADDR (DEV_ADDR)
	) u_i2c (
		.clk_in     (CLK_IN),
		.rst_in     (RST_IN),
		.scl_in     (SCL_IN),
		.sda_in     (SDA_IN),
		.rdata_in   (rdata),
		.sda_oe_out (SDA_OE_OUT),
		.wr_stb_out (wr_stb),
		.addr_out   (addr),
		.wdata_out  (wdata)
	);

	radc_subsec #(
		.DIV   (DIV),
		.CNT_W (SUBSEC_W)
	) u_subsec (
		.clk_in       (CLK_IN),
		.rst_in       (RST_IN),
		.run_req_in   (q_r.ctrl[CB_RUN]),
		.load_in      (q_r.load_p),
		.load_val_in  (COMP_VALUE_IN),
		.test_mode_in (q_r.ctrl[CB_TEST]),
		.auto_comp_in (q_r.ctrl[CB_AUTO]),
		.hour_top_in  (hour_top),
		.running_out  (running),
		.sec_tick_out (SEC_TICK_OUT),
		.comp_out     (COMP_APPLY_OUT)
	);

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	// counting stays 24-hour; format only changes presentation
	assign HOUR_12_OUT   = q_r.ctrl[CB_FMT];
	assign RUN_OUT       = running;
	assign ROUND_REQ_OUT = q_r.round_req;
	assign ALARM_IRQ_OUT = q_r.alarm_irq;
	assign SDA_OUT       = q_r.sda_lo;

endmodule // radc_ctrl
`default_nettype wire

// ---- rtl/radc_pkg.sv ----
// radc_pkg: register map, field positions, reset values and rates
package radc_pkg;

	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_SEC      = 8'h00;
	localparam logic [7:0] ADDR_HOUR     = 8'h02;
	localparam logic [7:0] ADDR_ALM_MON  = 8'h0C;
	localparam logic [7:0] ADDR_ALM_YEAR = 8'h0D;
	localparam logic [7:0] ADDR_CTRL     = 8'h10;
	localparam logic [7:0] ADDR_STAT     = 8'h11;
	localparam logic [7:0] ADDR_IRQC     = 8'h12;
	localparam int         NUM_TIME      = 7;
	localparam int         TIME_IDX_W    = 3;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int CB_VIEW  = 7;
	localparam int CB_SNAP  = 6;
	localparam int CB_LOAD  = 5;
	localparam int CB_TEST  = 4;
	localparam int CB_FMT   = 3;
	localparam int CB_AUTO  = 2;
	localparam int CB_ROUND = 1;
	localparam int CB_RUN   = 0;
	localparam int SB_RUN   = 1;
	localparam int IB_ALARM = 3;
	localparam int MB_TENS  = 4;
	localparam int UNITS_W  = 4;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [3:0] ALM_MON_UNITS_RST = 4'h1;
	localparam logic       ALM_MON_TENS_RST  = 1'b0;
	localparam logic [7:0] ALM_YEAR_RST      = 8'h00;
	localparam logic [7:0] CTRL_RST          = 8'h00;

	// ------------------------------------------------------------
	// rates and number formats
	// ------------------------------------------------------------
	localparam int         CLK_HZ    = 40_000_000;
	localparam int         TICK_HZ   = 32_768;
	localparam int         TICK_DIV  = CLK_HZ / TICK_HZ;
	localparam int         SUBSEC_W  = 15;
	localparam int         COMP_W    = 16;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [4:0] BCD_TEN   = 5'h0A;
	localparam logic [4:0] NOON      = 5'h0C;

endpackage

// ---- rtl/radc_subsec.sv ----
// radc_subsec: 32-kHz enable divider, run resync and sub-second counter
`timescale 1ns/10ps
`default_nettype none
module radc_subsec
	import radc_pkg::*;
#(
	parameter int DIV   = TICK_DIV,
	parameter int CNT_W = SUBSEC_W
)(
	input  wire logic              clk_in,
	input  wire logic              rst_in,
	input  wire logic              run_req_in,
	input  wire logic              load_in,
	input  wire logic [COMP_W-1:0] load_val_in,
	input  wire logic              test_mode_in,
	input  wire logic              auto_comp_in,
	input  wire logic              hour_top_in,
	output logic                   running_out,
	output logic                   sec_tick_out,
	output logic                   comp_out
);

	localparam int DIV_W = $clog2(DIV);

	typedef struct packed {
		logic [DIV_W-1:0] div;
		logic             run_s1;
		logic             run_s2;
		logic [CNT_W-1:0] cnt;
		logic             sec;
		logic             comp;
	} radc_sub_s;

	radc_sub_s q_r;
	radc_sub_s q_nxt;
	logic      tick;

	always_comb begin
		q_nxt = q_r;
		q_nxt.sec = 1'b0;
		q_nxt.comp = 1'b0;
		tick = (q_r.div == DIV_W'(DIV - 1));
		q_nxt.div = tick ? '0 : q_r.div + 1'b1;
		// run change takes two 32-kHz ticks to show
		if (tick) begin
			q_nxt.run_s1 = run_req_in;
			q_nxt.run_s2 = q_r.run_s1;
		end
		if (load_in) begin
			q_nxt.cnt = load_val_in[CNT_W-1:0];
		end else if (tick && q_r.run_s2) begin
			q_nxt.cnt = q_r.cnt + 1'b1;
			if (&q_r.cnt) begin
				q_nxt.sec = 1'b1;
				// with auto set, test mode compensates at every terminal count
				q_nxt.comp = auto_comp_in && (test_mode_in || hour_top_in);
			end
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			q_r <= '0;
		end else begin
			q_r <= q_nxt;
		end
	end

	assign running_out  = q_r.run_s2;
	assign sec_tick_out = q_r.sec;
	assign comp_out     = q_r.comp;

endmodule // radc_subsec
`default_nettype wire

// ---- rtl/radc_i2c.sv ----
// radc_i2c: control-interface slave with register pointer
`timescale 1ns/10ps
`default_nettype none
module radc_i2c
	import radc_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = 7'h2D
)(
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	input  wire logic [7:0] rdata_in,
	output logic            sda_oe_out,
	output logic            wr_stb_out,
	output logic [7:0]      addr_out,
	output logic [7:0]      wdata_out
);

	typedef enum logic [2:0] {
		I_IDLE, I_DEV, I_REG, I_WR, I_ACK, I_RD, I_RACK
	} radc_i2c_st_e;

	typedef struct packed {
		logic         scl_s1;
		logic         scl_s2;
		logic         scl_d;
		logic         sda_s1;
		logic         sda_s2;
		logic         sda_d;
		radc_i2c_st_e st;
		radc_i2c_st_e ret;
		logic [3:0]   bits;
		logic [7:0]   sh;
		logic [7:0]   ptr;
		logic         oe;
		logic         wr;
	} radc_i2c_s;

	localparam radc_i2c_s ST_RST = '{scl_s1: 1'b1, scl_s2: 1'b1,
		scl_d: 1'b1, sda_s1: 1'b1, sda_s2: 1'b1, sda_d: 1'b1,
		st: I_IDLE, ret: I_IDLE, default: '0};

	radc_i2c_s q_r;
	radc_i2c_s q_nxt;
	logic      rise;
	logic      fall;
	logic      start;
	logic      stop;

	always_comb begin
		q_nxt = q_r;
		q_nxt.wr = 1'b0;
		q_nxt.scl_s1 = scl_in;
		q_nxt.scl_s2 = q_r.scl_s1;
		q_nxt.scl_d = q_r.scl_s2;
		q_nxt.sda_s1 = sda_in;
		q_nxt.sda_s2 = q_r.sda_s1;
		q_nxt.sda_d = q_r.sda_s2;
		rise = q_r.scl_s2 && !q_r.scl_d;
		fall = !q_r.scl_s2 && q_r.scl_d;
		start = q_r.scl_s2 && q_r.scl_d && q_r.sda_d && !q_r.sda_s2;
		stop = q_r.scl_s2 && q_r.scl_d && !q_r.sda_d && q_r.sda_s2;
		// pointer steps after each written byte
		if (q_r.wr) begin
			q_nxt.ptr = q_r.ptr + 8'h01;
		end
		if (start) begin
			q_nxt.st = I_DEV;
			q_nxt.bits = '0;
			q_nxt.oe = 1'b0;
		end else if (stop) begin
			q_nxt.st = I_IDLE;
			q_nxt.oe = 1'b0;
		end else begin
			unique case (q_r.st)
				I_IDLE: begin
				end
				I_DEV, I_REG, I_WR: begin
					if (rise) begin
						q_nxt.sh = {q_r.sh[6:0], q_r.sda_s2};
						q_nxt.bits = q_r.bits + 4'h1;
					end else if (fall && q_r.bits == BYTE_BITS) begin
						q_nxt.st = I_ACK;
						q_nxt.oe = 1'b1;
						q_nxt.ret = I_WR;
						if (q_r.st == I_DEV) begin
							q_nxt.ret = q_r.sh[0] ? I_RD : I_REG;
							if (q_r.sh[7:1] != DEV_ADDR) begin
								q_nxt.st = I_IDLE;
								q_nxt.oe = 1'b0;
							end
						end else if (q_r.st == I_REG) begin
							q_nxt.ptr = q_r.sh;
						end else begin
							q_nxt.wr = 1'b1;
						end
					end
				end
				I_ACK: begin
					if (fall) begin
						q_nxt.st = q_r.ret;
						q_nxt.bits = '0;
						q_nxt.oe = 1'b0;
						if (q_r.ret == I_RD) begin
							q_nxt.oe = !rdata_in[7];
							q_nxt.sh = {rdata_in[6:0], 1'b0};
							q_nxt.bits = 4'h1;
						end
					end
				end
				I_RD: begin
					if (fall) begin
						if (q_r.bits == BYTE_BITS) begin
							q_nxt.oe = 1'b0;
							q_nxt.st = I_RACK;
						end else begin
							q_nxt.oe = !q_r.sh[7];
							q_nxt.sh = {q_r.sh[6:0], 1'b0};
							q_nxt.bits = q_r.bits + 4'h1;
						end
					end
				end
				I_RACK: begin
					if (rise) begin
						if (q_r.sda_s2) begin
							q_nxt.st = I_IDLE;
						end else begin
							q_nxt.ptr = q_r.ptr + 8'h01;
							q_nxt.st = I_ACK;
							q_nxt.ret = I_RD;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			q_r <= ST_RST;
		end else begin
			q_r <= q_nxt;
		end
	end

	assign sda_oe_out = q_r.oe;
	assign wr_stb_out = q_r.wr;
	assign addr_out   = q_r.ptr;
	assign wdata_out  = q_r.sh;

endmodule // radc_i2c
`default_nettype wire

// ---- test/radc_asserts.sv ----
// radc_asserts: port-level checks of the calendar clock control block
`timescale 1ns/10ps
`default_nettype none
module radc_asserts (
	input wire logic CLK_IN,
	input wire logic RST_IN,
	input wire logic SCL_IN,
	input wire logic ALARM_LOW_MATCH_IN,
	input wire logic RUN_OUT,
	input wire logic SEC_TICK_OUT,
	input wire logic COMP_APPLY_OUT,
	input wire logic HOUR_12_OUT,
	input wire logic ROUND_REQ_OUT,
	input wire logic ALARM_IRQ_OUT
);
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (RST_IN);
	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	AST_RESET_STATE:
	assert property (disable iff (1'b0) RST_IN |=> !RUN_OUT && !HOUR_12_OUT
		&& !ROUND_REQ_OUT && !ALARM_IRQ_OUT)
		else $error("outputs not cleared by reset");
	AST_NO_TICK_STOPPED:
	assert property (!RUN_OUT && !$past(RUN_OUT) |-> !SEC_TICK_OUT
		&& !COMP_APPLY_OUT)
		else $error("tick while clock stopped");
	AST_TICK_PULSE:
	assert property (SEC_TICK_OUT |=> !SEC_TICK_OUT)
		else $error("tick longer than one cycle");
	AST_COMP_WITH_TICK:
	assert property (COMP_APPLY_OUT |-> SEC_TICK_OUT)
		else $error("compensation away from counter wrap");
	AST_RUN_STEADY:
	assert property ($changed(RUN_OUT) |=> $stable(RUN_OUT) [*3])
		else $error("run flag not resynchronised");
	AST_ALARM_CAUSE:
	assert property (ALARM_IRQ_OUT |-> $past(ALARM_LOW_MATCH_IN))
		else $error("alarm without match");
	AST_ALARM_ONCE:
	assert property (ALARM_IRQ_OUT |=> !ALARM_IRQ_OUT)
		else $error("alarm pulse too long");
	AST_ROUND_PULSE:
	assert property (ROUND_REQ_OUT |-> !SCL_IN ##1 !ROUND_REQ_OUT)
		else $error("round request outside a write");
	AST_FMT_ON_WRITE:
	assert property ($changed(HOUR_12_OUT) |-> !SCL_IN && !$past(SCL_IN))
		else $error("hour format changed outside a write");
	cover property (SEC_TICK_OUT);
	cover property (COMP_APPLY_OUT);
	cover property (ALARM_IRQ_OUT);
	cover property (ROUND_REQ_OUT);
endmodule // radc_asserts
`default_nettype wire

// ---- test/radc_host.sv ----
// radc_host: control-interface master standing in for the host
`timescale 1ns/10ps
`default_nettype none
module radc_host
	import radc_pkg::*;
#(
	parameter logic [6:0] DEV = 7'h2D
)(
	input  wire logic clk_in,
	input  wire logic sda_in,
	output var  logic scl_out,
	output var  logic sda_oe_out
);
	logic [6:0] dev;
	logic       ack0;
	initial begin
		dev = DEV;
		ack0 = 1'b0;
		scl_out = 1'b1;
		sda_oe_out = 1'b0;
	end
	// ------------------------------------------------------------
	// bit and frame timing
	// ------------------------------------------------------------
	task automatic hw;
		repeat (6) @(posedge clk_in);
	endtask
	task automatic bit_io(input logic b, output logic r);
		hw;
		sda_oe_out <= ~b;
		hw;
		scl_out <= 1'b1;
		hw;
		hw;
		r = sda_in;
		scl_out <= 1'b0;
	endtask
	task automatic start_cond;
		hw;
		sda_oe_out <= 1'b0;
		hw;
		scl_out <= 1'b1;
		hw;
		sda_oe_out <= 1'b1;
		hw;
		scl_out <= 1'b0;
	endtask
	task automatic stop_cond;
		hw;
		sda_oe_out <= 1'b1;
		hw;
		scl_out <= 1'b1;
		hw;
		sda_oe_out <= 1'b0;
		hw;
	endtask
	task automatic xfer(input logic [7:0] d, input logic m,
		output logic [7:0] q, output logic k);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
			q[i] = r;
		end
		bit_io(m, r);
		k = ~r;
	endtask
	// ------------------------------------------------------------
	// register access
	// ------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		logic       k;
		start_cond;
		xfer({dev, 1'b0}, 1'b1, q, ack0);
		xfer(a, 1'b1, q, k);
		xfer(d, 1'b1, q, k);
		stop_cond;
	endtask
	task automatic rd_once(input logic [7:0] a, output logic [7:0] q);
		logic k;
		start_cond;
		xfer({dev, 1'b0}, 1'b1, q, ack0);
		xfer(a, 1'b1, q, k);
		start_cond;
		xfer({dev, 1'b1}, 1'b1, q, k);
		xfer(8'hFF, 1'b1, q, k);
		stop_cond;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] q);
		if (a == ADDR_CTRL) rd_once(a, q);
		rd_once(a, q);
	endtask
endmodule // radc_host
`default_nettype wire

// ---- test/test_radc_ctrl.sv ----
// test_radc_ctrl: register-level tests of the calendar clock control block
`timescale 1ns/10ps
`default_nettype none
module test_radc_ctrl;
	import radc_pkg::*;
	logic       clk = 1'b0;
	logic       rst = 1'b1;
	logic       scl;
	logic       host_oe;
	logic       dev_oe;
	logic       dev_out;
	wire logic  sda;
	logic [7:0] lv [7] = '{default: 8'h00};
	logic [15:0] comp = 16'h7FF8;
	logic       match = 1'b0;
	logic       rdone = 1'b0;
	logic       run, tick, capp, h12, rreq, irq;
	logic [7:0] mode [3] = '{8'h05, 8'h11, 8'h15};
	int         ncomp [3] = '{1, 0, 1};
	int         n_tick = 0, n_comp = 0, n_irq = 0, n_round = 0;
	int         err_total = 0;
	int         checked = 0;
	assign sda = ~host_oe & (~dev_oe | dev_out);
	always #12.5 clk = ~clk;
	always @(posedge clk) begin
		if (tick === 1'b1) n_tick++;
		if (capp === 1'b1) n_comp++;
		if (irq === 1'b1) n_irq++;
		if (rreq === 1'b1) n_round++;
	end
	radc_ctrl #(.DIV(4)) radc_ctrl_inst (
		.CLK_IN(clk), .RST_IN(rst), .SCL_IN(scl), .SDA_IN(sda),
		.SDA_OUT(dev_out), .SDA_OE_OUT(dev_oe), .LIVE_SEC_IN(lv[0]),
		.LIVE_MIN_IN(lv[1]), .LIVE_HOUR_IN(lv[2]), .LIVE_DAY_IN(lv[3]),
		.LIVE_MON_IN(lv[4]), .LIVE_YEAR_IN(lv[5]), .LIVE_WDAY_IN(lv[6]),
		.COMP_VALUE_IN(comp), .ALARM_LOW_MATCH_IN(match),
		.ROUND_DONE_IN(rdone), .RUN_OUT(run), .SEC_TICK_OUT(tick),
		.COMP_APPLY_OUT(capp), .HOUR_12_OUT(h12), .ROUND_REQ_OUT(rreq),
		.ALARM_IRQ_OUT(irq));
	radc_host radc_host_inst (.clk_in(clk), .sda_in(sda), .scl_out(scl),
		.sda_oe_out(host_oe));
	// ------------------------------------------------------------
	// access and compare tasks
	// ------------------------------------------------------------
	task automatic cmp_reg(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		checked++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic cmp_cnt(input string nm, input int e, input int g);
		checked++;
		if (g != e) begin
			err_total++;
			$display("CHECK FAILED %s expected %0d seen %0d", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		radc_host_inst.wr(a, d);
	endtask
	task automatic chk(input logic [7:0] a, input logic [7:0] e,
		input string nm);
		logic [7:0] q;
		radc_host_inst.rd(a, q);
		cmp_reg(nm, e, q);
	endtask
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (90000) @(posedge clk);
		err_total++;
		tally_and_finish;
	end
	// ------------------------------------------------------------
	// test sequence
	// ------------------------------------------------------------
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		chk(ADDR_ALM_MON, 8'h01, "month reset");
		chk(ADDR_ALM_YEAR, 8'h00, "year reset");
		chk(ADDR_CTRL, 8'h00, "ctrl reset");
		chk(ADDR_STAT, 8'h00, "status reset");
		wr(ADDR_ALM_MON, 8'hFF);
		chk(ADDR_ALM_MON, 8'h1F, "month fields");
		wr(ADDR_ALM_MON, 8'h12);
		chk(ADDR_ALM_MON, 8'h12, "month");
		wr(ADDR_ALM_YEAR, 8'h99);
		chk(ADDR_ALM_YEAR, 8'h99, "year");
		wr(8'h20, 8'h55);
		chk(8'h20, 8'h00, "unmapped");
		radc_host_inst.dev = 7'h2C;
		wr(ADDR_ALM_YEAR, 8'h00);
		radc_host_inst.dev = 7'h2D;
		cmp_reg("foreign address ack", 8'h00, {7'h0, radc_host_inst.ack0});
		chk(ADDR_ALM_YEAR, 8'h99, "year kept");
		for (int i = 0; i < 7; i++) lv[i] <= 8'(i + 1);
		wr(ADDR_CTRL, 8'h00);
		wr(ADDR_CTRL, 8'h40);
		for (int i = 0; i < 7; i++) lv[i] <= 8'(i + 8'h11);
		wr(ADDR_CTRL, 8'hC0);
		for (int i = 0; i < 7; i++) chk(8'(i), 8'(i + 1), "shadow");
		wr(ADDR_CTRL, 8'h80);
		wr(ADDR_CTRL, 8'hC0);
		chk(ADDR_SEC, 8'h11, "new shadow");
		wr(ADDR_CTRL, 8'h08);
		chk(ADDR_SEC, 8'h11, "live second");
		cmp_reg("12h pin", 8'h01, {7'h0, h12});
		chk(ADDR_HOUR, 8'h81, "pm hour");
		lv[2] <= 8'h00;
		chk(ADDR_HOUR, 8'h12, "midnight");
		wr(ADDR_CTRL, 8'h00);
		chk(ADDR_HOUR, 8'h00, "24h hour");
		n_round = 0;
		wr(ADDR_CTRL, 8'h02);
		cmp_cnt("round pulses", 1, n_round);
		chk(ADDR_CTRL, 8'h02, "round pending");
		@(posedge clk) rdone <= 1'b1;
		@(posedge clk) rdone <= 1'b0;
		chk(ADDR_CTRL, 8'h00, "round cleared");
		for (int i = 0; i < 3; i++) begin
			lv[0] <= 8'h00;
			lv[1] <= (i == 2) ? 8'h01 : 8'h00;
			wr(ADDR_CTRL, 8'h20);
			n_tick = 0;
			n_comp = 0;
			wr(ADDR_CTRL, mode[i]);
			chk(ADDR_STAT, 8'h02, "running");
			cmp_reg("run pin", 8'h01, {7'h0, run});
			wr(ADDR_CTRL, 8'h00);
			chk(ADDR_STAT, 8'h00, "stopped");
			cmp_reg("run pin low", 8'h00, {7'h0, run});
			cmp_cnt("ticks", 1, n_tick);
			cmp_cnt("compensations", ncomp[i], n_comp);
		end
		n_irq = 0;
		lv[4] <= 8'h12;
		lv[5] <= 8'h99;
		wr(ADDR_IRQC, 8'h08);
		chk(ADDR_IRQC, 8'h08, "irq enable");
		@(posedge clk) match <= 1'b1;
		repeat (20) @(posedge clk);
		cmp_cnt("alarm pulses", 1, n_irq);
		match <= 1'b0;
		lv[5] <= 8'h98;
		@(posedge clk) match <= 1'b1;
		repeat (20) @(posedge clk);
		cmp_cnt("alarm year differs", 1, n_irq);
		tally_and_finish;
	end
endmodule // test_radc_ctrl
bind radc_ctrl radc_asserts radc_asserts_inst (
	.CLK_IN(CLK_IN), .RST_IN(RST_IN), .SCL_IN(SCL_IN),
	.ALARM_LOW_MATCH_IN(ALARM_LOW_MATCH_IN), .RUN_OUT(RUN_OUT),
	.SEC_TICK_OUT(SEC_TICK_OUT), .COMP_APPLY_OUT(COMP_APPLY_OUT),
	.HOUR_12_OUT(HOUR_12_OUT), .ROUND_REQ_OUT(ROUND_REQ_OUT),
	.ALARM_IRQ_OUT(ALARM_IRQ_OUT));
`default_nettype wire
